// file: include/dtc_pkg.sv
// Constants and register map for the dual timer/counter block
// Function
// R1: Two 16-bit timers, two bytes, independently configured
// R2: Source select bit and two-bit mode field
// R3: Count register updates at phase C3
// R4: Pin sampled at C4; fall counts next C3
// R5: External count pin slower than clock/24
// R6: Speed bit: clock/12 default, clock/4 set
// R7: Mode 0: 13 bits, low byte top ignored
// R8: Count while run and (no gate or gate high)
// R9: Mode 0 wrap 1FFF to 0 sets flag
// R10: Mode 1 like mode 0 but 16 bits
// R11: Mode 1 wrap all ones sets flag
// R12: Mode 2 low byte wraps, reloads from high
// R13: Mode 2 gated by run, gate; either source
// R14: A mode 3 low byte uses A controls
// R15: A mode 3 high byte: clocks, B run/flag
// R16: B mode 3 freezes B count
// R17: A mode 3: B runs, no run/flag
// R18: Flags clear when their vector is taken
// R19: Software may set or clear each flag
package dtc_pkg;
	// Register offsets on the plain register port
	localparam logic [3:0] DTC_ADDR_MODE = 4'h0;
	localparam logic [3:0] DTC_ADDR_CTRL = 4'h1;
	localparam logic [3:0] DTC_ADDR_CLKC = 4'h2;
	localparam logic [3:0] DTC_ADDR_A_LOW = 4'h3;
	localparam logic [3:0] DTC_ADDR_A_HIGH = 4'h4;
	localparam logic [3:0] DTC_ADDR_B_LOW = 4'h5;
	localparam logic [3:0] DTC_ADDR_B_HIGH = 4'h6;
	localparam logic [3:0] DTC_ADDR_INT_STAT = 4'h7;
	localparam logic [3:0] DTC_ADDR_INT_MASK = 4'h8;
	// Mode register fields
	localparam int DTC_MODE_A_LSB = 0;
	localparam int DTC_CT_A_BIT = 2;
	localparam int DTC_GATE_A_BIT = 3;
	localparam int DTC_MODE_B_LSB = 4;
	localparam int DTC_CT_B_BIT = 6;
	localparam int DTC_GATE_B_BIT = 7;
	// Control register fields
	localparam int DTC_RUN_A_BIT = 4;
	localparam int DTC_FLAG_A_BIT = 5;
	localparam int DTC_RUN_B_BIT = 6;
	localparam int DTC_FLAG_B_BIT = 7;
	// Clock control register fields
	localparam int DTC_SPEED_A_BIT = 3;
	localparam int DTC_SPEED_B_BIT = 4;
	// Interrupt status and mask fields
	localparam int DTC_INT_A_BIT = 0;
	localparam int DTC_INT_B_BIT = 1;
	localparam logic [7:0] DTC_INT_USED = 8'h03;
	// Reset values
	localparam logic [7:0] DTC_MODE_RST = 8'h00;
	localparam logic [7:0] DTC_CTRL_RST = 8'h00;
	localparam logic [7:0] DTC_CLKC_RST = 8'h01;
	localparam logic [7:0] DTC_COUNT_RST = 8'h00;
	localparam logic [7:0] DTC_INT_RST = 8'h00;
	// Operating modes
	localparam logic [1:0] DTC_M_13BIT = 2'h0;
	localparam logic [1:0] DTC_M_16BIT = 2'h1;
	localparam logic [1:0] DTC_M_RELOAD = 2'h2;
	localparam logic [1:0] DTC_M_SPLIT = 2'h3;
	// Machine cycle timing: four clocks, phases C1..C4
	localparam logic [1:0] DTC_PH_C3 = 2'h2;
	localparam logic [1:0] DTC_PH_C4 = 2'h3;
	// Slow time base is one count every three machine cycles
	localparam logic [1:0] DTC_DIV3_LAST = 2'h2;
	localparam logic [1:0] DTC_DIV3_TICK = 2'h0;
	// Asynchronous inputs passed through the synchroniser
	localparam int DTC_SYNC_W = 4;
endpackage

// file: rtl/dtc_sync.sv
// Two flip-flop synchroniser for the pin inputs of the timer block
`timescale 1ns/1ps
module dtc_sync
	import dtc_pkg::*;
(
	input wire logic clk_sys, // System clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [DTC_SYNC_W-1:0] async_in, // Raw pin levels
	output logic [DTC_SYNC_W-1:0] sync_out // Levels in clk_sys domain
);
	logic [DTC_SYNC_W-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// file: rtl/dtc_top.sv
// Dual timer/counter with four modes, register port and interrupt
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module dtc_top
	import dtc_pkg::*;
(
	input wire logic clk_sys, // System clock, 40 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic [3:0] reg_addr, // Register offset
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [7:0] reg_rdata, // Read data, cycle after strobe
	input wire logic timer_a_count_pin, // External count pin, timer A
	input wire logic timer_b_count_pin, // External count pin, timer B
	input wire logic external_gate_input_a, // Gate input, timer A
	input wire logic external_gate_input_b, // Gate input, timer B
	input wire logic vector_taken_a, // Controller enters A's service
	input wire logic vector_taken_b, // Controller enters B's service
	output logic timer_a_overflow, // Overflow flag A
	output logic timer_b_overflow, // Overflow flag B
	output logic serial_clock_tick, // One pulse per timer B wrap
	output logic irq // Level interrupt, unmasked status set
);
	////////////////////////////////////////////////////////////////
	// Declarations
	logic [7:0] timer_mode_register;
	logic [7:0] timer_control_register;
	logic [7:0] clock_control_register;
	logic [7:0] timer_a_low_byte;
	logic [7:0] timer_a_high_byte;
	logic [7:0] timer_b_low_byte;
	logic [7:0] timer_b_high_byte;
	logic [7:0] int_stat_reg;
	logic [7:0] int_mask_reg;
	logic [1:0] phase_reg;
	logic [1:0] div3_reg;
	logic [DTC_SYNC_W-1:0] pins_sync;
	logic pin_a_smp_reg;
	logic pin_a_old_reg;
	logic pin_b_smp_reg;
	logic pin_b_old_reg;
	logic [7:0] a_low_next;
	logic [7:0] a_high_next;
	logic [7:0] b_low_next;
	logic [7:0] b_high_next;
	logic ovf_a_ev;
	logic ovf_b_ev;
	logic b_wrap_ev;
	logic [16:0] a_res;
	logic [16:0] b_res;
	logic [8:0] a_low_sum;
	logic [8:0] a_high_sum;
	logic [1:0] mode_a;
	logic [1:0] mode_b;
	logic a_split;
	logic at_c3;
	logic at_c4;
	logic tick_slow;
	logic tick_a;
	logic tick_b;
	logic fall_a;
	logic fall_b;
	logic gate_ok_a;
	logic gate_ok_b;
	logic en_a;
	logic en_b;
	logic step_a;
	logic step_b;
	logic step_a_high;
	logic wr_mode;
	logic wr_ctrl;
	logic wr_clkc;
	logic wr_stat;
	logic wr_mask;

	////////////////////////////////////////////////////////////////
	// One count step for modes 0 to 2; result is {wrap, high, low}
	function automatic logic [16:0] dtc_count_step(
		input logic [1:0] mode,
		input logic [7:0] high_byte,
		input logic [7:0] low_byte
	);
		logic [13:0] sum13;
		logic [16:0] sum16;
		logic [16:0] res;
		sum13 = {1'b0, high_byte, low_byte[4:0]} + 14'h0001;
		sum16 = {1'b0, high_byte, low_byte} + 17'h00001;
		res = {1'b0, high_byte, low_byte};
		case (mode)
			DTC_M_13BIT: begin
				// Top three low bits stay put and never count
				res = {sum13[13], sum13[12:5], low_byte[7:5], sum13[4:0]}; // R7 R9
			end
			DTC_M_16BIT: begin
				res = sum16; // R10 R11
			end
			DTC_M_RELOAD: begin
				// Wrap reloads low from high, high untouched
				if (low_byte == 8'hff) begin
					res = {1'b1, high_byte, high_byte}; // R12
				end else begin
					res = {1'b0, high_byte, low_byte + 8'h01}; // R12
				end
			end
			default: begin
				res = {1'b0, high_byte, low_byte};
			end
		endcase
		return res;
	endfunction

	////////////////////////////////////////////////////////////////
	// Field decode
	assign mode_a = timer_mode_register[DTC_MODE_A_LSB +: 2]; // R2
	assign mode_b = timer_mode_register[DTC_MODE_B_LSB +: 2]; // R2
	assign a_split = (mode_a == DTC_M_SPLIT);
	assign wr_mode = reg_wr && (reg_addr == DTC_ADDR_MODE);
	assign wr_ctrl = reg_wr && (reg_addr == DTC_ADDR_CTRL);
	assign wr_clkc = reg_wr && (reg_addr == DTC_ADDR_CLKC);
	assign wr_stat = reg_wr && (reg_addr == DTC_ADDR_INT_STAT);
	assign wr_mask = reg_wr && (reg_addr == DTC_ADDR_INT_MASK);

	////////////////////////////////////////////////////////////////
	// Pin synchroniser; count pins and gates come from outside
	dtc_sync u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in({external_gate_input_b, external_gate_input_a,
			timer_b_count_pin, timer_a_count_pin}),
		.sync_out(pins_sync)
	);

	////////////////////////////////////////////////////////////////
	// Machine cycle phase and divide-by-three time base
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= 2'h0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
		end
	end

	// Slow base advances once per machine cycle, at its end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div3_reg <= 2'h0;
		end else if (phase_reg == DTC_PH_C4) begin
			div3_reg <= (div3_reg == DTC_DIV3_LAST) ? 2'h0 : div3_reg + 2'h1;
		end
	end

	assign at_c3 = (phase_reg == DTC_PH_C3);
	assign at_c4 = (phase_reg == DTC_PH_C4);
	assign tick_slow = (div3_reg == DTC_DIV3_TICK);
	// Fast base counts every machine cycle: clock/4
	assign tick_a = clock_control_register[DTC_SPEED_A_BIT] ? 1'b1 : tick_slow; // R6
	assign tick_b = clock_control_register[DTC_SPEED_B_BIT] ? 1'b1 : tick_slow; // R6

	////////////////////////////////////////////////////////////////
	// Count pin sampling once per machine cycle at C4
	// Samples hold for a whole machine cycle, so the edge found at
	// C4 is seen at the following C3 exactly once. Pins faster than
	// clock/8 will lose edges; that is the pin driver's concern.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_a_smp_reg <= 1'b0;
			pin_a_old_reg <= 1'b0;
			pin_b_smp_reg <= 1'b0;
			pin_b_old_reg <= 1'b0;
		end else if (at_c4) begin
			pin_a_smp_reg <= pins_sync[0]; // R4
			pin_a_old_reg <= pin_a_smp_reg; // R4
			pin_b_smp_reg <= pins_sync[1]; // R4
			pin_b_old_reg <= pin_b_smp_reg; // R4
		end
	end

	assign fall_a = pin_a_old_reg && !pin_a_smp_reg; // R4 R5
	assign fall_b = pin_b_old_reg && !pin_b_smp_reg; // R4 R5

	////////////////////////////////////////////////////////////////
	// Enables and count steps, only ever at C3
	assign gate_ok_a = !timer_mode_register[DTC_GATE_A_BIT] || pins_sync[2]; // R8
	assign gate_ok_b = !timer_mode_register[DTC_GATE_B_BIT] || pins_sync[3]; // R8
	assign en_a = timer_control_register[DTC_RUN_A_BIT] && gate_ok_a; // R8 R13 R14
	// With A split, B no longer listens to its run bit
	assign en_b = a_split ? gate_ok_b
		: (timer_control_register[DTC_RUN_B_BIT] && gate_ok_b); // R17
	assign step_a = at_c3 && en_a
		&& (timer_mode_register[DTC_CT_A_BIT] ? fall_a : tick_a); // R2 R3
	// B in mode 3 simply holds its value
	assign step_b = at_c3 && en_b && (mode_b != DTC_M_SPLIT)
		&& (timer_mode_register[DTC_CT_B_BIT] ? fall_b : tick_b); // R3 R16
	// Split high byte counts prescaled clocks on B's run bit
	assign step_a_high = at_c3 && a_split
		&& timer_control_register[DTC_RUN_B_BIT] && tick_a; // R15

	////////////////////////////////////////////////////////////////
	// Next count values; a software write to a byte wins over counting
	always_comb begin
		a_res = dtc_count_step(mode_a, timer_a_high_byte, timer_a_low_byte);
		b_res = dtc_count_step(mode_b, timer_b_high_byte, timer_b_low_byte);
		a_low_sum = {1'b0, timer_a_low_byte} + 9'h001;
		a_high_sum = {1'b0, timer_a_high_byte} + 9'h001;
		a_low_next = timer_a_low_byte;
		a_high_next = timer_a_high_byte;
		b_low_next = timer_b_low_byte;
		b_high_next = timer_b_high_byte;
		ovf_a_ev = 1'b0;
		ovf_b_ev = 1'b0;
		b_wrap_ev = 1'b0;
		if (a_split) begin
			if (step_a) begin
				a_low_next = a_low_sum[7:0]; // R14
				ovf_a_ev = a_low_sum[8]; // R14
			end
			if (step_a_high) begin
				a_high_next = a_high_sum[7:0]; // R15
				ovf_b_ev = a_high_sum[8]; // R15
			end
		end else if (step_a) begin
			a_high_next = a_res[15:8]; // R1
			a_low_next = a_res[7:0]; // R1
			ovf_a_ev = a_res[16]; // R9 R11 R12
		end
		if (step_b) begin
			b_high_next = b_res[15:8]; // R1
			b_low_next = b_res[7:0]; // R1
			b_wrap_ev = b_res[16];
			// B's wraps reach its flag only when A is not split
			if (!a_split) begin
				ovf_b_ev = b_res[16]; // R17
			end
		end
		if (reg_wr && (reg_addr == DTC_ADDR_A_LOW)) begin
			a_low_next = reg_wdata;
		end
		if (reg_wr && (reg_addr == DTC_ADDR_A_HIGH)) begin
			a_high_next = reg_wdata;
		end
		if (reg_wr && (reg_addr == DTC_ADDR_B_LOW)) begin
			b_low_next = reg_wdata;
		end
		if (reg_wr && (reg_addr == DTC_ADDR_B_HIGH)) begin
			b_high_next = reg_wdata;
		end
	end

	// Count bytes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			timer_a_low_byte <= DTC_COUNT_RST;
			timer_a_high_byte <= DTC_COUNT_RST;
			timer_b_low_byte <= DTC_COUNT_RST;
			timer_b_high_byte <= DTC_COUNT_RST;
		end else begin
			timer_a_low_byte <= a_low_next; // R3
			timer_a_high_byte <= a_high_next; // R3
			timer_b_low_byte <= b_low_next; // R3
			timer_b_high_byte <= b_high_next; // R3
		end
	end

	////////////////////////////////////////////////////////////////
	// Mode and clock control registers, written by software
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			timer_mode_register <= DTC_MODE_RST;
		end else if (wr_mode) begin
			timer_mode_register <= reg_wdata; // R1 R2
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clock_control_register <= DTC_CLKC_RST;
		end else if (wr_clkc) begin
			clock_control_register <= reg_wdata; // R6
		end
	end

	////////////////////////////////////////////////////////////////
	// Control register: run bits and overflow flags
	// Priority per flag: hardware set, then software write, then the
	// vector clear, so an overflow is never lost to a clear.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			timer_control_register <= DTC_CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				timer_control_register[3:0] <= reg_wdata[3:0];
				timer_control_register[DTC_RUN_A_BIT] <= reg_wdata[DTC_RUN_A_BIT];
				timer_control_register[DTC_RUN_B_BIT] <= reg_wdata[DTC_RUN_B_BIT];
			end
			if (ovf_a_ev) begin
				timer_control_register[DTC_FLAG_A_BIT] <= 1'b1; // R9 R12 R14
			end else if (wr_ctrl) begin
				timer_control_register[DTC_FLAG_A_BIT] <= reg_wdata[DTC_FLAG_A_BIT]; // R19
			end else if (vector_taken_a) begin
				timer_control_register[DTC_FLAG_A_BIT] <= 1'b0; // R18
			end
			if (ovf_b_ev) begin
				timer_control_register[DTC_FLAG_B_BIT] <= 1'b1; // R11 R15
			end else if (wr_ctrl) begin
				timer_control_register[DTC_FLAG_B_BIT] <= reg_wdata[DTC_FLAG_B_BIT]; // R19
			end else if (vector_taken_b) begin
				timer_control_register[DTC_FLAG_B_BIT] <= 1'b0; // R18
			end
		end
	end

	// Flag outputs to the interrupt controller, from the flag flops
	assign timer_a_overflow = timer_control_register[DTC_FLAG_A_BIT];
	assign timer_b_overflow = timer_control_register[DTC_FLAG_B_BIT];

	////////////////////////////////////////////////////////////////
	// Serial port tick: any B wrap, even while A is split
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			serial_clock_tick <= 1'b0;
		end else begin
			serial_clock_tick <= b_wrap_ev; // R17
		end
	end

	////////////////////////////////////////////////////////////////
	// Sticky interrupt status, write one to clear; set beats clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			int_stat_reg <= DTC_INT_RST;
		end else begin
			if (ovf_a_ev) begin
				int_stat_reg[DTC_INT_A_BIT] <= 1'b1;
			end else if (wr_stat && reg_wdata[DTC_INT_A_BIT]) begin
				int_stat_reg[DTC_INT_A_BIT] <= 1'b0;
			end
			if (ovf_b_ev) begin
				int_stat_reg[DTC_INT_B_BIT] <= 1'b1;
			end else if (wr_stat && reg_wdata[DTC_INT_B_BIT]) begin
				int_stat_reg[DTC_INT_B_BIT] <= 1'b0;
			end
		end
	end

	// Mask, only the defined bits are stored
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			int_mask_reg <= DTC_INT_RST;
		end else if (wr_mask) begin
			int_mask_reg <= reg_wdata & DTC_INT_USED;
		end
	end

	// Interrupt is registered, so it trails the status by one cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_stat_reg & int_mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////
	// Read port: data stand one cycle after the strobe, else zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				DTC_ADDR_MODE: reg_rdata <= timer_mode_register;
				DTC_ADDR_CTRL: reg_rdata <= timer_control_register;
				DTC_ADDR_CLKC: reg_rdata <= clock_control_register;
				DTC_ADDR_A_LOW: reg_rdata <= timer_a_low_byte;
				DTC_ADDR_A_HIGH: reg_rdata <= timer_a_high_byte;
				DTC_ADDR_B_LOW: reg_rdata <= timer_b_low_byte;
				DTC_ADDR_B_HIGH: reg_rdata <= timer_b_high_byte;
				DTC_ADDR_INT_STAT: reg_rdata <= int_stat_reg;
				DTC_ADDR_INT_MASK: reg_rdata <= int_mask_reg;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule

// file: test/dtc_assertions.sv
// Concurrent checks on the dual timer/counter ports
`timescale 1ns/1ps
module dtc_checker (
	input wire logic clk_sys, // Clock
	input wire logic rst_n, // Reset, low
	input wire logic reg_wr, // Write strobe
	input wire logic vector_taken_a, // Vector A
	input wire logic vector_taken_b, // Vector B
	input wire logic timer_a_overflow, // Flag A
	input wire logic timer_b_overflow, // Flag B
	input wire logic serial_clock_tick, // B wrap pulse
	input wire logic irq // Interrupt
);
	logic [1:0] ph_reg;
	////////////////////////
	// Own copy of the machine-cycle phase, restarted at C1 by reset like the block's
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ph_reg <= 2'h0;
		end else begin
			ph_reg <= ph_reg + 2'h1;
		end
	end
	////////////////////////
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// A wrap lands on the C3 edge, so a new flag is first seen in C4
	a_flag_a_phase: assert property ($rose(timer_a_overflow) && !$past(reg_wr) |-> ph_reg == 2'h3)
		else $error("flag A rose outside the count phase");
	a_flag_b_phase: assert property ($rose(timer_b_overflow) && !$past(reg_wr) |-> ph_reg == 2'h3)
		else $error("flag B rose outside the count phase");
	a_tick_after_wrap: assert property (serial_clock_tick |-> ph_reg == 2'h3 ##1 !serial_clock_tick)
		else $error("serial tick misplaced or too long");
	// A wrap in the C3 cycle beats the vector, so that cycle is left out
	a_vector_clears_a: assert property (vector_taken_a && !reg_wr && ph_reg != 2'h2 |=> !timer_a_overflow)
		else $error("vector A did not clear flag A");
	a_vector_clears_b: assert property (vector_taken_b && !reg_wr && ph_reg != 2'h2 |=> !timer_b_overflow)
		else $error("vector B did not clear flag B");
	a_flag_a_drop: assert property ($fell(timer_a_overflow) |-> $past(vector_taken_a) || $past(reg_wr))
		else $error("flag A fell without cause");
	a_flag_b_drop: assert property ($fell(timer_b_overflow) |-> $past(vector_taken_b) || $past(reg_wr))
		else $error("flag B fell without cause");
	a_irq_rise_cause: assert property ($rose(irq) |-> $past(reg_wr, 2) || $past(timer_a_overflow) || $past(timer_b_overflow))
		else $error("interrupt rose without event");
	a_irq_fall_cause: assert property ($fell(irq) |-> $past(reg_wr, 2))
		else $error("interrupt fell without a write");
	c_flag_a: cover property ($rose(timer_a_overflow));
	c_flag_b: cover property ($rose(timer_b_overflow));
	c_tick: cover property (serial_clock_tick);
	c_irq_drop: cover property ($fell(irq));
endmodule
bind dtc_top dtc_checker chk_u (.clk_sys, .rst_n, .reg_wr, .vector_taken_a, .vector_taken_b,
	.timer_a_overflow, .timer_b_overflow, .serial_clock_tick, .irq);

// file: test/dtc_far_model.sv
// Interrupt controller and count/gate pin drivers facing the timer block
`timescale 1ns/1ps
module dtc_far_model (
	input wire logic clk_sys, // Clock
	output logic pin_a, // Count pin A
	output logic pin_b, // Count pin B
	output logic gate_a, // Gate A
	output logic gate_b, // Gate B
	output logic vec_a, // Vector taken A
	output logic vec_b // Vector taken B
);
	// Pins idle high so the first low is a clean falling edge
	initial begin
		pin_a = 1'b1;
		pin_b = 1'b1;
		gate_a = 1'b1;
		gate_b = 1'b1;
		vec_a = 1'b0;
		vec_b = 1'b0;
	end
	// Each level held three machine cycles: edge recognition needs two plus sync
	task automatic pulse_pin(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			pin_a <= 1'b0;
			repeat (12) @(posedge clk_sys);
			pin_a <= 1'b1;
			repeat (12) @(posedge clk_sys);
		end
	endtask
	// Gate level changes just after an edge
	task automatic set_gate(input logic g);
		@(posedge clk_sys);
		gate_a <= g;
	endtask
	// One-cycle service entry; only called while the flag is set
	task automatic take_vec(input bit b);
		@(posedge clk_sys);
		if (b) begin
			vec_b <= 1'b1;
		end else begin
			vec_a <= 1'b1;
		end
		@(posedge clk_sys);
		vec_a <= 1'b0;
		vec_b <= 1'b0;
	endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module testbench;
	import dtc_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [7:0] rv;
	logic pin_a, pin_b, gate_a, gate_b, vec_a, vec_b;
	logic flag_a, flag_b, tick, irq;
	int miscompares = 0;
	int n_tests = 0;
	////////////////////////
	always #12.5 clk_sys = ~clk_sys;
	dtc_top dut_u (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.timer_a_count_pin(pin_a), .timer_b_count_pin(pin_b), .external_gate_input_a(gate_a),
		.external_gate_input_b(gate_b), .vector_taken_a(vec_a), .vector_taken_b(vec_b),
		.timer_a_overflow(flag_a), .timer_b_overflow(flag_b), .serial_clock_tick(tick), .irq);
	dtc_far_model far_u (.clk_sys, .pin_a, .pin_b, .gate_a, .gate_b, .vec_a, .vec_b);
	////////////////////////
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
		n_tests++;
		if (s !== x) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, s);
		end
	endtask
	// Bus cycles: strobes rise and fall just after an edge, never back to back
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	// Bounded wait for an overflow flag
	task automatic wait_f(input bit b, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(posedge clk_sys);
			#1;
			if ((b ? flag_b : flag_a) === 1'b1) break;
		end
		if (i == lim) begin
			chk("flag wait", 8'h00, 8'h01);
			test_done();
		end
	endtask
	////////////////////////
	task automatic t_reset();
		wr(4'hf, 8'hff);
		for (int a = 0; a < 10; a++) begin
			rd(4'(a));
			chk("reset value", rv, (a == 2) ? 8'h01 : 8'h00);
		end
		$display("test reset done");
	endtask
	task automatic t_mode1();
		wr(DTC_ADDR_INT_MASK, 8'h03);
		wr(DTC_ADDR_CLKC, 8'h09);
		wr(DTC_ADDR_A_HIGH, 8'hff);
		wr(DTC_ADDR_A_LOW, 8'hfc);
		wr(DTC_ADDR_MODE, 8'h01);
		wr(DTC_ADDR_CTRL, 8'h10);
		wait_f(0, 40);
		wr(DTC_ADDR_CTRL, 8'h20);
		rd(DTC_ADDR_A_HIGH);
		chk("mode1 high", rv, 8'h00);
		rd(DTC_ADDR_INT_STAT);
		chk("status", rv, 8'h01);
		chk("irq on", {7'h00, irq}, 8'h01);
		far_u.take_vec(0);
		#1 chk("flag A vector", {7'h00, flag_a}, 8'h00);
		wr(DTC_ADDR_INT_STAT, 8'h01);
		repeat (2) @(posedge clk_sys);
		#1 chk("irq off", {7'h00, irq}, 8'h00);
		$display("test mode1 done");
	endtask
	// Slow base leaves twelve clocks after the wrap to stop before the next count
	task automatic t_mode0();
		wr(DTC_ADDR_CLKC, 8'h01);
		wr(DTC_ADDR_A_HIGH, 8'hff);
		wr(DTC_ADDR_A_LOW, 8'hff);
		wr(DTC_ADDR_MODE, 8'h00);
		wr(DTC_ADDR_CTRL, 8'h10);
		wait_f(0, 80);
		wr(DTC_ADDR_CTRL, 8'h00);
		rd(DTC_ADDR_A_HIGH);
		chk("mode0 high", rv, 8'h00);
		rd(DTC_ADDR_A_LOW);
		chk("mode0 low", rv, 8'he0);
		$display("test mode0 done");
	endtask
	task automatic t_rate();
		logic [7:0] e;
		wr(DTC_ADDR_MODE, 8'h01);
		for (int f = 0; f < 2; f++) begin
			e = f ? 8'h04 : 8'h0c;
			wr(DTC_ADDR_CLKC, f ? 8'h01 : 8'h09);
			wr(DTC_ADDR_A_LOW, 8'h00);
			wr(DTC_ADDR_CTRL, 8'h10);
			repeat (48) @(posedge clk_sys);
			wr(DTC_ADDR_CTRL, 8'h00);
			rd(DTC_ADDR_A_LOW);
			chk("time base", {7'h00, rv >= e - 8'h01 && rv <= e + 8'h01}, 8'h01);
		end
		$display("test rate done");
	endtask
	task automatic t_gate();
		wr(DTC_ADDR_CLKC, 8'h09);
		wr(DTC_ADDR_MODE, 8'h09);
		wr(DTC_ADDR_A_LOW, 8'h00);
		far_u.set_gate(1'b0);
		wr(DTC_ADDR_CTRL, 8'h10);
		repeat (40) @(posedge clk_sys);
		rd(DTC_ADDR_A_LOW);
		chk("gate closed", rv, 8'h00);
		far_u.set_gate(1'b1);
		repeat (40) @(posedge clk_sys);
		wr(DTC_ADDR_CTRL, 8'h00);
		rd(DTC_ADDR_A_LOW);
		chk("gate open", {7'h00, rv != 8'h00}, 8'h01);
		$display("test gate done");
	endtask
	task automatic t_count();
		wr(DTC_ADDR_MODE, 8'h05);
		wr(DTC_ADDR_A_LOW, 8'h00);
		wr(DTC_ADDR_CTRL, 8'h10);
		far_u.pulse_pin(3);
		repeat (16) @(posedge clk_sys);
		wr(DTC_ADDR_CTRL, 8'h00);
		rd(DTC_ADDR_A_LOW);
		chk("pin count", rv, 8'h03);
		$display("test count done");
	endtask
	task automatic t_reload();
		wr(DTC_ADDR_CLKC, 8'h01);
		wr(DTC_ADDR_B_HIGH, 8'h80);
		wr(DTC_ADDR_B_LOW, 8'hfe);
		wr(DTC_ADDR_MODE, 8'h20);
		wr(DTC_ADDR_CTRL, 8'h40);
		wait_f(1, 100);
		chk("serial tick", {7'h00, tick}, 8'h01);
		wr(DTC_ADDR_CTRL, 8'h00);
		rd(DTC_ADDR_B_LOW);
		chk("reload low", rv, 8'h80);
		rd(DTC_ADDR_B_HIGH);
		chk("reload high", rv, 8'h80);
		$display("test reload done");
	endtask
	task automatic t_split();
		wr(DTC_ADDR_CLKC, 8'h09);
		wr(DTC_ADDR_B_LOW, 8'h05);
		wr(DTC_ADDR_A_HIGH, 8'hff);
		wr(DTC_ADDR_A_LOW, 8'h00);
		wr(DTC_ADDR_MODE, 8'h33);
		wr(DTC_ADDR_CTRL, 8'h50);
		wait_f(1, 40);
		chk("split flag A", {7'h00, flag_a}, 8'h00);
		// Stop both halves before the next C3 but keep flag B for the vector
		wr(DTC_ADDR_CTRL, 8'h80);
		far_u.take_vec(1);
		#1 chk("flag B vector", {7'h00, flag_b}, 8'h00);
		rd(DTC_ADDR_A_HIGH);
		chk("split high", rv, 8'h00);
		rd(DTC_ADDR_A_LOW);
		chk("split low", {7'h00, rv != 8'h00}, 8'h01);
		rd(DTC_ADDR_B_LOW);
		chk("B frozen", rv, 8'h05);
		wr(DTC_ADDR_MODE, 8'h13);
		repeat (40) @(posedge clk_sys);
		rd(DTC_ADDR_B_LOW);
		chk("B without run", {7'h00, rv != 8'h05}, 8'h01);
		wr(DTC_ADDR_MODE, 8'h00);
		$display("test split done");
	endtask
	task automatic t_soft();
		wr(DTC_ADDR_CTRL, 8'h80);
		chk("soft set", {7'h00, flag_b}, 8'h01);
		wr(DTC_ADDR_CTRL, 8'h00);
		chk("soft clear", {7'h00, flag_b}, 8'h00);
		$display("test soft done");
	endtask
	////////////////////////
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_mode1();
		t_mode0();
		t_rate();
		t_gate();
		t_count();
		t_reload();
		t_split();
		t_soft();
		test_done();
	end
endmodule
